// [shared/flash_cmd_pkg.sv]
// Constants for the flash command and status logic
package flash_cmd_pkg;
   localparam logic [15:0] STATUS_ADDR   = 16'h1825;
   localparam logic [15:0] COMMAND_ADDR  = 16'h1826;
   localparam logic [15:0] ARRAY_BASE    = 16'hC000;
   localparam logic [15:0] ARRAY_LAST    = 16'hFFFF;
   localparam logic [7:0]  STATUS_RESET  = 8'hC0;
   localparam logic [7:0]  COMMAND_RESET = 8'h00;
   localparam int BIT_BUF_EMPTY = 7;
   localparam int BIT_COMPLETE  = 6;
   localparam int BIT_PROTECT   = 5;
   localparam int BIT_ACCERR    = 4;
   localparam int BIT_BLANK     = 2;
   localparam logic [7:0] CMD_BLANK_CHECK = 8'h05;
   localparam logic [7:0] CMD_BYTE_PROG   = 8'h20;
   localparam logic [7:0] CMD_BURST_PROG  = 8'h25;
   localparam logic [7:0] CMD_PAGE_ERASE  = 8'h40;
   localparam logic [7:0] CMD_MASS_ERASE  = 8'h41;
   localparam int unsigned PAGE_BYTES     = 512;
   localparam logic [7:0] ERASED_BYTE     = 8'hFF;
   localparam logic [1:0] SEC_UNSECURED   = 2'h2;
   localparam logic [7:0] PROG_CYCLES_RST  = 8'h08;
   localparam logic [7:0] ERASE_CYCLES_RST = 8'h20;
endpackage

// [rtl/flash_command_status_logic.sv]
// Flash command sequencing and status flags of the embedded flash controller
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module flash_command_status_logic
   import flash_cmd_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   input  wire logic              clock,
   input  wire logic              reset_n,
   input  wire logic [15:0]       reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic      [7:0]        reg_rdata,
   input  wire logic [15:0]       array_wr_addr,
   input  wire logic [7:0]        array_wr_data,
   input  wire logic              array_wr,
   input  wire logic              divider_set,
   input  wire logic              stop_request,
   input  wire logic [15:0]       protect_limit,
   input  wire logic              protect_disable,
   input  wire logic [7:0]        array_rd_data,
   output logic      [15:0]       array_addr,
   output logic      [7:0]        array_data,
   output logic                   array_program,
   output logic                   array_erase,
   output logic      [1:0]        security_state_code,
   output logic                   busy
);
   import flash_cmd_pkg::*;

   typedef enum logic [2:0] {IDLE, PROGRAM, ERASE, BLANK_SCAN, DONE} phase_e;
   typedef enum logic [1:0] {SEQ_WAIT_DATA, SEQ_WAIT_CODE, SEQ_WAIT_LAUNCH} seq_e;

   typedef struct packed {
      phase_e      phase;
      seq_e        seq;
      logic        buf_empty;
      logic        complete;
      logic        protect_viol;
      logic        acc_err;
      logic        blank;
      logic [7:0]  cmd;
      logic [15:0] addr;
      logic [7:0]  data;
      logic        pend_valid;
      logic [7:0]  pend_cmd;
      logic [15:0] pend_addr;
      logic [7:0]  pend_data;
      logic [7:0]  timer;
      logic [15:0] scan_addr;
      logic        scan_ok;
      logic [1:0]  sec;
      logic [7:0]  rdata;
      logic        stop_s1;
      logic        stop_s2;
   } state_s;

   state_s st_q;
   state_s st_d;

   logic       wr_status;
   logic       wr_command;
   logic       launch;
   logic       code_legal;
   logic       code_needs_div;
   logic       target_protected;
   logic [15:0] page_mask;

   assign wr_status  = reg_write && (reg_addr == STATUS_ADDR);
   assign wr_command = reg_write && (reg_addr == COMMAND_ADDR);
   assign launch     = wr_status && reg_wdata[BIT_BUF_EMPTY] && st_q.buf_empty;
   assign page_mask  = ~16'(PAGE_BYTES - 1);

   always_comb begin
      unique case (st_q.cmd)
         CMD_BLANK_CHECK, CMD_BYTE_PROG, CMD_BURST_PROG,
         CMD_PAGE_ERASE, CMD_MASS_ERASE: code_legal = 1'b1;
         default:                        code_legal = 1'b0;
      endcase
      code_needs_div = (st_q.cmd != CMD_BLANK_CHECK);
      // Protected region runs from the array base up to the limit when enabled
      if (protect_disable) begin
         target_protected = 1'b0;
      end else if (st_q.cmd == CMD_MASS_ERASE) begin
         target_protected = 1'b1;
      end else if (st_q.cmd == CMD_BLANK_CHECK) begin
         target_protected = 1'b0;
      end else begin
         target_protected = (st_q.addr <= protect_limit);
      end
   end

   always_comb begin
      st_d = st_q;
      st_d.stop_s1 = stop_request;
      st_d.stop_s2 = st_q.stop_s1;
      st_d.rdata   = 8'h00;

      ////////////////////////////////////////////////////////////////////////
      // Register reads
      if (reg_read) begin
         if (reg_addr == STATUS_ADDR) begin
            st_d.rdata = 8'h00;
            st_d.rdata[BIT_BUF_EMPTY] = st_q.buf_empty;
            st_d.rdata[BIT_COMPLETE]  = st_q.complete;
            st_d.rdata[BIT_PROTECT]   = st_q.protect_viol;
            st_d.rdata[BIT_ACCERR]    = st_q.acc_err;
            st_d.rdata[BIT_BLANK]     = st_q.blank;
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // Write sequence: array latch, then command code, then launch
      if (array_wr) begin
         if (st_q.seq == SEQ_WAIT_DATA && st_q.buf_empty) begin
            st_d.addr = array_wr_addr;
            st_d.data = array_wr_data;
            st_d.seq  = SEQ_WAIT_CODE;
         end else begin
            st_d.acc_err = 1'b1;
            st_d.seq     = SEQ_WAIT_DATA;
         end
      end
      if (wr_command) begin
         if (st_q.seq == SEQ_WAIT_CODE) begin
            st_d.cmd = reg_wdata;
            st_d.seq = SEQ_WAIT_LAUNCH;
         end else begin
            st_d.acc_err = 1'b1;
            st_d.seq     = SEQ_WAIT_DATA;
         end
      end

      // Clearing by writing 1; a hardware set later in this process wins
      if (wr_status && reg_wdata[BIT_PROTECT]) begin
         st_d.protect_viol = 1'b0;
      end
      if (wr_status && reg_wdata[BIT_ACCERR]) begin
         st_d.acc_err = 1'b0;
      end

      if (launch) begin
         st_d.seq = SEQ_WAIT_DATA;
         if (st_q.seq != SEQ_WAIT_LAUNCH || !code_legal) begin
            st_d.acc_err = 1'b1;
         end else if (code_needs_div && !divider_set) begin
            st_d.acc_err = 1'b1;
         end else if (target_protected) begin
            st_d.protect_viol = 1'b1;
         end else if (st_q.phase != IDLE) begin
            // Busy: only a burst after a burst may wait in the buffer
            if (st_q.cmd == CMD_BURST_PROG && st_q.pend_cmd == CMD_BURST_PROG) begin
               st_d.pend_valid = 1'b1;
               st_d.pend_addr  = st_q.addr;
               st_d.pend_data  = st_q.data;
               st_d.buf_empty  = 1'b0;
               st_d.complete   = 1'b0;
            end else begin
               st_d.acc_err = 1'b1;
            end
         end else begin
            st_d.buf_empty  = 1'b1;
            st_d.complete   = 1'b0;
            st_d.blank      = 1'b0;
            st_d.pend_cmd   = st_q.cmd;
            st_d.timer      = (st_q.cmd == CMD_PAGE_ERASE || st_q.cmd == CMD_MASS_ERASE)
                              ? ERASE_CYCLES_RST : PROG_CYCLES_RST;
            st_d.scan_addr  = ARRAY_BASE;
            st_d.scan_ok    = 1'b1;
            unique case (st_q.cmd)
               CMD_BLANK_CHECK: st_d.phase = BLANK_SCAN;
               CMD_PAGE_ERASE: begin
                  st_d.phase = ERASE;
                  st_d.addr  = st_q.addr & page_mask;
               end
               CMD_MASS_ERASE: st_d.phase = ERASE;
               default:        st_d.phase = PROGRAM;
            endcase
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // Execution
      unique case (st_q.phase)
         IDLE: begin
         end
         PROGRAM, ERASE: begin
            if (st_q.timer != 8'h00) begin
               st_d.timer = st_q.timer - 8'h01;
            end else if (st_q.pend_valid) begin
               st_d.pend_valid = 1'b0;
               st_d.addr       = st_q.pend_addr;
               st_d.data       = st_q.pend_data;
               st_d.buf_empty  = 1'b1;
               st_d.timer      = PROG_CYCLES_RST;
            end else begin
               st_d.phase = DONE;
            end
         end
         BLANK_SCAN: begin
            if (array_rd_data != ERASED_BYTE) begin
               st_d.scan_ok = 1'b0;
            end
            if (st_q.scan_addr == ARRAY_LAST) begin
               st_d.phase = DONE;
               if (st_q.scan_ok && array_rd_data == ERASED_BYTE) begin
                  st_d.blank = 1'b1;
                  st_d.sec   = SEC_UNSECURED;
               end
            end else begin
               st_d.scan_addr = st_q.scan_addr + 16'h0001;
            end
         end
         DONE: begin
            st_d.phase = IDLE;
         end
      endcase

      if (st_q.phase == DONE && !st_q.pend_valid && st_q.buf_empty) begin
         st_d.complete = 1'b1;
         st_d.pend_cmd = 8'h00;
      end

      // A stop entered mid-command aborts it
      if (st_q.stop_s2 && st_q.phase != IDLE) begin
         st_d.acc_err    = 1'b1;
         st_d.phase      = IDLE;
         st_d.pend_valid = 1'b0;
         st_d.buf_empty  = 1'b1;
         st_d.complete   = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_q              <= '0;
         st_q.phase        <= IDLE;
         st_q.seq          <= SEQ_WAIT_DATA;
         st_q.buf_empty    <= STATUS_RESET[BIT_BUF_EMPTY];
         st_q.complete     <= STATUS_RESET[BIT_COMPLETE];
         st_q.cmd          <= COMMAND_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata           = st_q.rdata;
   assign array_addr          = (st_q.phase == BLANK_SCAN) ? st_q.scan_addr : st_q.addr;
   assign array_data          = st_q.data;
   assign array_program       = (st_q.phase == PROGRAM);
   assign array_erase         = (st_q.phase == ERASE);
   assign security_state_code = st_q.sec;
   assign busy                = (st_q.phase != IDLE);
endmodule

// [test/flash_command_status_logic_sva.sv]
// Port-level assertions for the flash command and status logic
`timescale 1ns/1ps
module flash_status_checker
   import flash_cmd_pkg::*;
(
   input wire logic        clock,
   input wire logic        reset_n,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [7:0]  reg_rdata,
   input wire logic        stop_request,
   input wire logic        array_program,
   input wire logic        array_erase,
   input wire logic [1:0]  security_state_code,
   input wire logic        busy
);
   // Longest command is the blank scan of the whole array plus its closing cycle
   localparam logic [15:0] BUSY_LIMIT = 16'h4268;
   logic [15:0] busy_cycles_q;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         busy_cycles_q <= 16'h0000;
      end else if (!busy) begin
         busy_cycles_q <= 16'h0000;
      end else if (busy_cycles_q != 16'hFFFF) begin
         busy_cycles_q <= busy_cycles_q + 16'h0001;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_reserved_bits_zero: assert property (reg_read && reg_addr == STATUS_ADDR |=>
      (reg_rdata & 8'h0B) == 8'h00) else $error("reserved status bits not zero");
   // Skips a restart right after a one-cycle idle gap; a queued burst moves in without dropping busy
   a_launch_by_write: assert property ($rose(busy) && !$past(busy, 2) |->
      $past(reg_write) && $past(reg_addr) == STATUS_ADDR && $past(reg_wdata[7]))
      else $error("command started without launch write");
   a_busy_bounded: assert property (busy_cycles_q < BUSY_LIMIT)
      else $error("command never completed");
   a_stop_aborts: assert property (busy && stop_request |-> ##[1:5] !busy)
      else $error("stop did not end the command");
   a_erase_min_len: assert property ($rose(array_erase) |-> array_erase[*8])
      else $error("erase pulse too short");
   a_one_action: assert property (!(array_program && array_erase))
      else $error("program and erase together");
   a_idle_no_array: assert property (!busy |-> !array_program && !array_erase)
      else $error("array action while idle");
   a_sec_value: assert property (!$stable(security_state_code) |->
      security_state_code == SEC_UNSECURED) else $error("bad security code change");
   a_sec_after_scan: assert property (!$stable(security_state_code) |->
      $past(busy) || $past(busy, 2)) else $error("security changed without scan");
   c_program: cover property ($rose(array_program));
   c_erase: cover property ($rose(array_erase));
   c_unsecure: cover property ($rose(security_state_code[1]));
   c_stop: cover property (busy && stop_request);
endmodule
bind flash_command_status_logic flash_status_checker flash_status_checker_i (
   .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .stop_request(stop_request), .array_program(array_program),
   .array_erase(array_erase), .security_state_code(security_state_code), .busy(busy));

// [test/tb_top.sv]
// Self-checking bench for the flash command and status logic
`timescale 1ns/1ps
module tb_top;
   import flash_cmd_pkg::*;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_write = 1'b0;
   logic        reg_read = 1'b0;
   logic [15:0] wr_addr = 16'h0000;
   logic [7:0]  wr_data = 8'h00;
   logic        wr_pulse = 1'b0;
   logic        divider_set = 1'b1;
   logic        stop_request = 1'b0;
   logic        protect_disable = 1'b1;
   logic [7:0]  reg_rdata, array_data;
   logic [15:0] array_addr;
   logic        array_program, array_erase, busy;
   logic [1:0]  security_state_code;
   int          miscompares = 0;
   int          n_checks = 0;
   int          cycles = 0;
   logic [7:0]  codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
   logic [7:0]  expect_st [5] = '{8'hC4, 8'hC0, 8'hC0, 8'hC0, 8'hC0};
   flash_command_status_logic flash_command_status_logic_i (
      .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .array_wr_addr(wr_addr), .array_wr_data(wr_data), .array_wr(wr_pulse),
      .divider_set(divider_set), .stop_request(stop_request),
      .protect_limit(16'hDFFF), .protect_disable(protect_disable),
      .array_rd_data(8'hFF), .array_addr(array_addr), .array_data(array_data),
      .array_program(array_program), .array_erase(array_erase),
      .security_state_code(security_state_code), .busy(busy));
   initial begin
      forever #10 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////
   task conclude();
      $display("Checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   // Full software order: array write, command code, then launch
   task seq(input logic [15:0] a, input logic [7:0] c);
      @(posedge clock);
      wr_addr <= a;
      wr_data <= 8'h5A;
      wr_pulse <= 1'b1;
      @(posedge clock);
      wr_pulse <= 1'b0;
      wr(COMMAND_ADDR, c);
      wr(STATUS_ADDR, 8'h80);
   endtask
   // Polls for the end of the command, bounded beyond the longest scan
   task fin(input logic [7:0] e);
      #1;
      for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge clock);
      rd(STATUS_ADDR, e);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      rd(STATUS_ADDR, STATUS_RESET);
      rd(COMMAND_ADDR, COMMAND_RESET);
      rd(16'h1830, 8'h00);
      wr(STATUS_ADDR, 8'h4F);
      rd(STATUS_ADDR, 8'hC0);
      $display("Test reset and reserved bits finished");
      seq(16'hF000, CMD_BYTE_PROG);
      #1 chk(array_program, 1'b1);
      chk(array_addr, 16'hF000);
      fin(8'hC0);
      for (int k = 0; k < 5; k++) begin
         seq(16'hF000, codes[k]);
         fin(expect_st[k]);
         if (k == 0) chk(security_state_code, SEC_UNSECURED);
      end
      $display("Test command codes finished");
      seq(16'hF000, CMD_BURST_PROG);
      seq(16'hF001, CMD_BURST_PROG);
      rd(STATUS_ADDR, 8'h00);
      fin(8'hC0);
      $display("Test burst queue finished");
      seq(16'hF000, 8'h33);
      rd(STATUS_ADDR, 8'hD0);
      wr(STATUS_ADDR, 8'h00);
      rd(STATUS_ADDR, 8'hD0);
      wr(STATUS_ADDR, 8'h10);
      rd(STATUS_ADDR, 8'hC0);
      wr(COMMAND_ADDR, CMD_BYTE_PROG);
      wr(STATUS_ADDR, 8'h80);
      fin(8'hD0);
      wr(STATUS_ADDR, 8'h10);
      divider_set <= 1'b0;
      seq(16'hF000, CMD_PAGE_ERASE);
      fin(8'hD0);
      wr(STATUS_ADDR, 8'h10);
      divider_set <= 1'b1;
      $display("Test access errors finished");
      protect_disable <= 1'b0;
      seq(16'hC100, CMD_BYTE_PROG);
      fin(8'hE0);
      wr(STATUS_ADDR, 8'h00);
      rd(STATUS_ADDR, 8'hE0);
      wr(STATUS_ADDR, 8'h20);
      rd(STATUS_ADDR, 8'hC0);
      $display("Test protection finished");
      seq(16'hF200, CMD_PAGE_ERASE);
      repeat (10) @(posedge clock);
      stop_request <= 1'b1;
      fin(8'hD0);
      stop_request <= 1'b0;
      $display("Test stop abort finished");
      conclude();
   end
endmodule
